// ===== hdl/indexed_config_region_regs.sv
`timescale 1ns/1ps
module indexed_config_region_regs
	import cfg_regs_pkg::*;
#(
	parameter bit WIDE_MAP = 1'b0
)
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic io_valid_in,
	input wire logic io_write_in,
	input wire logic [15:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	output logic io_claim_out,
	output logic io_external_out,
	output logic [7:0] io_rdata_out,
	input wire logic [31:0] mem_addr_in,
	input wire logic mem_write_in,
	input wire logic mem_data_in,
	input wire logic in_sysmgmt_in,
	input wire logic hold_enter_in,
	input wire logic addr_bit20_mask_in,
	input wire logic cache_enable_in,
	input wire logic cache_flush_in,
	input wire logic suspend_request_in,
	input wire logic suspend_ack_in,
	input wire logic sysmgmt_interrupt_in,
	input wire logic sysmgmt_strobe_in,
	output logic uncacheable_out,
	output logic write_protect_out,
	output logic sysmgmt_space_out,
	output logic force_external_out,
	output logic use_main_mem_out,
	output logic addr_bit20_mask_out,
	output logic cache_enable_out,
	output logic cache_flush_out,
	output logic direct_mapped_out,
	output logic suspend_request_out,
	output logic suspend_ack_out,
	output logic suspend_ack_oe_out,
	output logic sysmgmt_interrupt_out,
	output logic sysmgmt_strobe_out,
	output logic sysmgmt_strobe_oe_out
);

	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	logic [7:0] config_control_0_r;
	logic [7:0] config_control_1_r;
	logic [7:0] index_r;
	logic [7:0] rdata_r;
	logic [23:0] region_r [4];
	io_state_t state_r;
	region_if rg ();

	region_match u_match
	(
		.rg(rg)
	);

	// --------------------------------------------------------------
	// Index decoding
	// --------------------------------------------------------------
	// Returns region number and byte lane for an index, lane 3 means none
	function automatic logic [3:0] region_sel(input logic [7:0] idx, input bit wide);
		logic [3:0] r;
		r = 4'hF;
		for (int i = 0; i < 4; i++)
		begin
			if (!wide && idx == 8'(IDX_N_REGION1 + 3 * i))
				r = {2'(i), 2'd0};
			else if (!wide && idx == 8'(IDX_N_REGION1 + 3 * i + 1))
				r = {2'(i), 2'd1};
			else if (wide && idx >= 8'(IDX_W_REGION1 + 3 * i) &&
				idx <= 8'(IDX_W_REGION1 + 3 * i + 2))
				r = {2'(i), 2'(idx - 8'(IDX_W_REGION1 + 3 * i))};
		end
		return r;
	endfunction

	wire is_index_port = io_valid_in && (io_addr_in == INDEX_PORT);
	wire is_data_port = io_valid_in && (io_addr_in == DATA_PORT);
	wire in_range = (index_r >= IDX_LOW) && (index_r <= IDX_HIGH);
	wire [3:0] sel = region_sel(index_r, WIDE_MAP);
	wire sel_region = (sel[1:0] != 2'd3);
	wire [1:0] sel_num = sel[3:2];
	wire [1:0] sel_lane = sel[1:0];
	wire sel_ctrl0 = (index_r == IDX_CTRL0);
	wire sel_ctrl1 = (index_r == IDX_CTRL1);
	// Reserved indices inside the range are claimed but read zero
	wire data_claim = is_data_port && (state_r == IO_ARMED) && in_range;
	wire idx_claim = is_index_port;
	wire data_write = data_claim && io_write_in;
	wire [7:0] read_value = sel_ctrl0 ? config_control_0_r :
		sel_ctrl1 ? config_control_1_r :
		sel_region ? region_r[sel_num][8 * sel_lane +: 8] : 8'h00;

	assign io_claim_out = idx_claim || data_claim;
	// Data port without a fresh index, or out of range, runs externally
	assign io_external_out = is_data_port && !data_claim;
	assign io_rdata_out = rdata_r;

	// --------------------------------------------------------------
	// Index/data sequencing
	// --------------------------------------------------------------
	// One data access consumes the index, so a repeat goes off-chip
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			state_r <= IO_IDLE;
		else if (is_index_port && io_write_in)
			state_r <= IO_ARMED;
		else if (is_data_port)
			state_r <= IO_IDLE;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			index_r <= 8'h00;
		else if (is_index_port && io_write_in)
			index_r <= io_wdata_in;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rdata_r <= 8'h00;
		else if (data_claim && !io_write_in)
			rdata_r <= read_value;
		else if (idx_claim && !io_write_in)
			rdata_r <= index_r;
	end

	// --------------------------------------------------------------
	// Configuration registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			config_control_0_r <= CTRL_RESET;
			config_control_1_r <= CTRL_RESET;
		end
		else if (data_write && sel_ctrl0)
			config_control_0_r <= io_wdata_in;
		else if (data_write && sel_ctrl1)
			config_control_1_r <= io_wdata_in & 8'hFE; // bit 0 reserved
	end

	// Narrow map keeps the low 16 bits: lane 1 is high byte, lane 0 holds
	// start bits and the size code, stored here in the wide layout.
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			for (int i = 0; i < 4; i++)
				region_r[i] <= 24'h00_0000;
		end
		else if (data_write && sel_region)
			region_r[sel_num][8 * sel_lane +: 8] <= io_wdata_in;
	end

	// --------------------------------------------------------------
	// Region matching
	// --------------------------------------------------------------
	// Layout: lane 0 bits 7:4 start[15:12], 3:0 size; lanes above start[31:16]
	for (genvar i = 0; i < 4; i++)
	begin : g_rg
		assign rg.size_code[i] = region_r[i][3:0];
		assign rg.start_addr[i] = WIDE_MAP ? region_r[i][23:4] :
			{8'h00, region_r[i][15:8], region_r[i][7:4]};
	end
	assign rg.addr = mem_addr_in;

	wire [2:0] protect_bits = config_control_1_r[C1_REGION1_PROTECT +: 3];
	wire region4_sm = config_control_1_r[C1_REGION4_SYSMGMT];
	wire sm_access = config_control_1_r[C1_SYSMGMT_MEM_ACCESS];
	wire sm_pins = config_control_1_r[C1_SYSMGMT_PINS_EN];
	wire main_mem = config_control_1_r[C1_MAIN_MEM_DATA_ACCESS];
	wire [2:0] wp_hit = rg.hit[2:0] & protect_bits;
	wire [2:0] nc_hit = rg.hit[2:0] & ~protect_bits;
	wire mb_low = config_control_0_r[C0_MEGABYTE_LOW_UNCACHED] &&
		((mem_addr_in & MB_64K_MASK) == 32'h0000_0000);
	wire upper_mem = config_control_0_r[C0_UPPER_MEMORY_UNCACHED] &&
		(mem_addr_in >= UPPER_LOW) && (mem_addr_in < UPPER_HIGH);
	wire in_sm_space = rg.hit[3] && region4_sm;
	wire sm_ready = region4_sm && (rg.size_code[3] != SIZE_DISABLED);

	// --------------------------------------------------------------
	// Cache and memory steering
	// --------------------------------------------------------------
	assign uncacheable_out = mb_low || upper_mem || (|nc_hit) || rg.hit[3];
	assign write_protect_out = (|wp_hit) && mem_write_in;
	assign sysmgmt_space_out = in_sm_space && !(main_mem && mem_data_in &&
		(in_sysmgmt_in || sm_access));
	assign force_external_out = in_sm_space && sm_access;
	assign use_main_mem_out = main_mem && mem_data_in && (in_sysmgmt_in || sm_access);
	assign direct_mapped_out = config_control_0_r[C0_CACHE_ORG_SELECT];

	// --------------------------------------------------------------
	// Pin gating
	// --------------------------------------------------------------
	assign addr_bit20_mask_out = addr_bit20_mask_in &&
		config_control_0_r[C0_ADDR_BIT20_MASK_PIN_EN];
	assign cache_enable_out = cache_enable_in &&
		config_control_0_r[C0_CACHE_ENABLE_PIN_EN];
	// Hold entry flush also rides on the flush output
	assign cache_flush_out = (cache_flush_in && config_control_0_r[C0_FLUSH_PIN_EN]) ||
		(hold_enter_in && config_control_0_r[C0_PURGE_ON_HOLD]);
	assign suspend_request_out = suspend_request_in &&
		config_control_0_r[C0_SUSPEND_PINS_EN];
	assign suspend_ack_out = suspend_ack_in;
	assign suspend_ack_oe_out = config_control_0_r[C0_SUSPEND_PINS_EN];
	// Interrupt needs pins on, region 4 sized as sysmgmt and no forced access
	assign sysmgmt_interrupt_out = sysmgmt_interrupt_in && sm_pins && sm_ready &&
		!sm_access;
	assign sysmgmt_strobe_out = sysmgmt_strobe_in || force_external_out;
	assign sysmgmt_strobe_oe_out = sm_pins;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	a_second_data_external: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(is_data_port && state_r == IO_IDLE) |-> (io_external_out && !io_claim_out))
		else $error("repeated data access was claimed");
	a_data_disarms: assert property (@(posedge clk_in) disable iff (!nrst_in)
		is_data_port |=> (state_r == IO_IDLE))
		else $error("data access left the index armed");
	a_range_external: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(is_data_port && !in_range) |-> (io_external_out && !io_claim_out))
		else $error("out of range index claimed");
	a_ctrl0_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(data_write && sel_ctrl0) |=> (config_control_0_r == $past(io_wdata_in)))
		else $error("control 0 not written");
	a_suspend_float: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!config_control_0_r[C0_SUSPEND_PINS_EN] |-> (!suspend_ack_oe_out &&
		!suspend_request_out))
		else $error("suspend pins active while disabled");
	a_strobe_float: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!sm_pins |-> (!sysmgmt_strobe_oe_out && !sysmgmt_interrupt_out))
		else $error("sysmgmt pins active while disabled");
	a_smi_sized: assert property (@(posedge clk_in) disable iff (!nrst_in)
		sysmgmt_interrupt_out |-> (rg.size_code[3] != SIZE_DISABLED && region4_sm))
		else $error("interrupt with region 4 unsized");
	a_upper_uncached: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(config_control_0_r[C0_UPPER_MEMORY_UNCACHED] && mem_addr_in == 32'h000B_8000)
		|-> uncacheable_out)
		else $error("upper memory cached");
	a_hold_flush: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(hold_enter_in && config_control_0_r[C0_PURGE_ON_HOLD]) |-> cache_flush_out)
		else $error("no flush on hold");
	a_pin_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!config_control_0_r[C0_CACHE_ENABLE_PIN_EN] |-> !cache_enable_out)
		else $error("cache enable pin not gated");
	a_flush_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!config_control_0_r[C0_FLUSH_PIN_EN] && !hold_enter_in) |-> !cache_flush_out)
		else $error("flush pin not gated");
	a_mb_low_uncached: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(config_control_0_r[C0_MEGABYTE_LOW_UNCACHED] && mem_addr_in[19:16] == 4'h0)
		|-> uncacheable_out)
		else $error("low 64K of a megabyte cached");
	// Region checks watch regions 1 and 4 only; the other two share region 1's path
	a_protect_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rg.hit[0] && protect_bits[0] && mem_write_in) |-> write_protect_out)
		else $error("protected region write not flagged");
	a_unprotected_uncached: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rg.hit[0] && !protect_bits[0]) |-> uncacheable_out)
		else $error("plain region cached");
	a_region4_uncached: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rg.hit[3] |-> uncacheable_out)
		else $error("region 4 cached");
	a_region_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rg.size_code[0] == SIZE_DISABLED) |-> !rg.hit[0])
		else $error("disabled region hit");
	a_sm_external: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(in_sm_space && sm_access) |-> (force_external_out && sysmgmt_strobe_out))
		else $error("sysmgmt access not external");
	a_smi_gated: assert property (@(posedge clk_in) disable iff (!nrst_in)
		sm_access |-> !sysmgmt_interrupt_out)
		else $error("interrupt passed during forced access");
	a_main_mem: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(main_mem && mem_data_in && sm_access) |-> (use_main_mem_out && !sysmgmt_space_out))
		else $error("data access not steered to main memory");

endmodule

// ===== hdl/cfg_regs_pkg.sv
package cfg_regs_pkg;

	// --------------------------------------------------------------
	// Port addresses and index map
	// --------------------------------------------------------------
	localparam logic [15:0] INDEX_PORT = 16'h0022;
	localparam logic [15:0] DATA_PORT = 16'h0023;
	localparam logic [7:0] IDX_LOW = 8'hC0;
	localparam logic [7:0] IDX_HIGH = 8'hCF;
	localparam logic [7:0] IDX_CTRL0 = 8'hC0;
	localparam logic [7:0] IDX_CTRL1 = 8'hC1;
	// Narrow map: first index of each 16-bit region pair
	localparam logic [7:0] IDX_N_REGION1 = 8'hC5;
	localparam logic [7:0] IDX_N_REGION2 = 8'hC8;
	localparam logic [7:0] IDX_N_REGION3 = 8'hCB;
	localparam logic [7:0] IDX_N_REGION4 = 8'hCE;
	// Wide map: first index of each 24-bit region triple
	localparam logic [7:0] IDX_W_REGION1 = 8'hC4;
	localparam logic [7:0] IDX_W_REGION2 = 8'hC7;
	localparam logic [7:0] IDX_W_REGION3 = 8'hCA;
	localparam logic [7:0] IDX_W_REGION4 = 8'hCD;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// --------------------------------------------------------------
	// Control register 0 fields
	// --------------------------------------------------------------
	localparam int C0_MEGABYTE_LOW_UNCACHED = 0;
	localparam int C0_UPPER_MEMORY_UNCACHED = 1;
	localparam int C0_ADDR_BIT20_MASK_PIN_EN = 2;
	localparam int C0_CACHE_ENABLE_PIN_EN = 3;
	localparam int C0_FLUSH_PIN_EN = 4;
	localparam int C0_PURGE_ON_HOLD = 5;
	localparam int C0_CACHE_ORG_SELECT = 6;
	localparam int C0_SUSPEND_PINS_EN = 7;

	// --------------------------------------------------------------
	// Control register 1 fields
	// --------------------------------------------------------------
	localparam int C1_SYSMGMT_PINS_EN = 1;
	localparam int C1_SYSMGMT_MEM_ACCESS = 2;
	localparam int C1_MAIN_MEM_DATA_ACCESS = 3;
	localparam int C1_REGION1_PROTECT = 4;
	localparam int C1_REGION4_SYSMGMT = 7;

	// --------------------------------------------------------------
	// Region decode constants
	// --------------------------------------------------------------
	localparam logic [3:0] SIZE_DISABLED = 4'h0;
	localparam logic [3:0] SIZE_4G = 4'hF;
	localparam int SIZE_SHIFT_BASE = 11;
	localparam logic [31:0] MB_64K_MASK = 32'h000F_0000;
	localparam logic [31:0] UPPER_LOW = 32'h000A_0000;
	localparam logic [31:0] UPPER_HIGH = 32'h0010_0000;
	localparam int NUM_REGIONS = 4;

	typedef enum logic [1:0] {IO_IDLE, IO_ARMED} io_state_t;

endpackage

// ===== hdl/region_if.sv
`timescale 1ns/1ps
// Region registers as seen by the matching logic
interface region_if;
	localparam int NUM_W = 20;
	logic [NUM_W-1:0] start_addr [4];
	logic [3:0] size_code [4];
	logic [3:0] hit;
	logic [31:0] addr;
	modport owner (output start_addr, output size_code, output addr, input hit);
	modport matcher (input start_addr, input size_code, input addr, output hit);
endinterface

// ===== hdl/region_match.sv
`timescale 1ns/1ps
module region_match
	import cfg_regs_pkg::*;
(
	region_if.matcher rg
);

	// --------------------------------------------------------------
	// Address-region hit detection
	// --------------------------------------------------------------
	// Mask of address bits that lie inside a block of this size code
	function automatic logic [31:0] block_mask(input logic [3:0] code);
		logic [31:0] m;
		m = 32'h0000_0000;
		if (code == SIZE_4G)
			m = 32'hFFFF_FFFF;
		else if (code != SIZE_DISABLED)
			m = 32'hFFFF_FFFF >> (5'(32 - SIZE_SHIFT_BASE) - 5'(code)); // Code n spans n+11 bits
		return m;
	endfunction

	// Start address is held as the top 20 bits, a 4-KByte unit
	for (genvar i = 0; i < 4; i++)
	begin : g_hit
		wire [31:0] start_full = {rg.start_addr[i], 12'h000};
		wire [31:0] mask = block_mask(rg.size_code[i]);
		assign rg.hit[i] = (rg.size_code[i] != SIZE_DISABLED) &&
			((rg.addr & ~mask) == (start_full & ~mask));
	end

endmodule

// ===== test/io_core_model.sv
`timescale 1ns/1ps
// Processor side issuing single I/O cycles to the index and data ports
module io_core_model
(
	input wire logic clk_in,
	input wire logic claim_in,
	input wire logic external_in,
	input wire logic [7:0] rdata_in,
	output logic valid_out = 1'b0,
	output logic write_out = 1'b0,
	output logic [15:0] addr_out = 16'h0000,
	output logic [7:0] wdata_out = 8'h00
);
	// One access held for one edge; idle address and data lines show inverted values so stale data cannot pass
	task automatic cycle(input logic wr, input logic [15:0] adr, input logic [7:0] wd,
		output logic clm, output logic ext, output logic [7:0] rd);
		@(posedge clk_in);
		valid_out <= 1'b1;
		write_out <= wr;
		addr_out <= adr;
		wdata_out <= wd;
		@(posedge clk_in);
		clm = claim_in;
		ext = external_in;
		valid_out <= 1'b0;
		addr_out <= ~adr;
		wdata_out <= ~wd;
		@(posedge clk_in);
		rd = rdata_in;
	endtask
endmodule

// ===== test/indexed_config_region_regs_tb_top.sv
`timescale 1ns/1ps
module indexed_config_region_regs_tb_top
	import cfg_regs_pkg::*;
;
	// ------------------------------------------------
	// Clock, reset and stimulus signals
	// ------------------------------------------------
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic io_valid_in, io_write_in, io_claim_out, io_external_out;
	logic [15:0] io_addr_in;
	logic [7:0] io_wdata_in, io_rdata_out, rd;
	logic [31:0] mem_addr_in = 32'h0000_0000;
	logic mem_write_in = 1'b0, mem_data_in = 1'b1, in_sysmgmt_in = 1'b0, hold_enter_in = 1'b0;
	logic a20_in = 1'b1, ken_in = 1'b1, flush_in = 1'b1, sreq_in = 1'b1, sack_in = 1'b1;
	logic smi_in = 1'b1, sstb_in = 1'b1, claim, ext;
	logic a20_out, ken_out, flush_out, sreq_out, sack_out, sack_oe, smi_out, sstb_out, sstb_oe;
	logic unc_out, wp_out, sms_out, fext_out, main_out, dm_out, unc_w;
	logic [7:0] rdata_w;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;

	always #10 clk_in = ~clk_in;

	indexed_config_region_regs u_indexed_config_region_regs (.clk_in(clk_in), .nrst_in(nrst_in),
		.io_valid_in(io_valid_in), .io_write_in(io_write_in), .io_addr_in(io_addr_in),
		.io_wdata_in(io_wdata_in), .io_claim_out(io_claim_out), .io_external_out(io_external_out),
		.io_rdata_out(io_rdata_out), .mem_addr_in(mem_addr_in), .mem_write_in(mem_write_in),
		.mem_data_in(mem_data_in), .in_sysmgmt_in(in_sysmgmt_in), .hold_enter_in(hold_enter_in),
		.addr_bit20_mask_in(a20_in), .cache_enable_in(ken_in), .cache_flush_in(flush_in),
		.suspend_request_in(sreq_in), .suspend_ack_in(sack_in), .sysmgmt_interrupt_in(smi_in),
		.sysmgmt_strobe_in(sstb_in), .uncacheable_out(unc_out), .write_protect_out(wp_out),
		.sysmgmt_space_out(sms_out), .force_external_out(fext_out), .use_main_mem_out(main_out),
		.addr_bit20_mask_out(a20_out), .cache_enable_out(ken_out), .cache_flush_out(flush_out),
		.direct_mapped_out(dm_out), .suspend_request_out(sreq_out), .suspend_ack_out(sack_out),
		.suspend_ack_oe_out(sack_oe), .sysmgmt_interrupt_out(smi_out),
		.sysmgmt_strobe_out(sstb_out), .sysmgmt_strobe_oe_out(sstb_oe));

	// Second copy on the same bus, built with the 24-bit region map
	indexed_config_region_regs #(.WIDE_MAP(1'b1)) u_indexed_config_region_regs_wide (
		.clk_in(clk_in), .nrst_in(nrst_in), .io_valid_in(io_valid_in),
		.io_write_in(io_write_in), .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
		.io_claim_out(), .io_external_out(), .io_rdata_out(rdata_w),
		.mem_addr_in(mem_addr_in), .mem_write_in(mem_write_in), .mem_data_in(mem_data_in),
		.in_sysmgmt_in(in_sysmgmt_in), .hold_enter_in(hold_enter_in),
		.addr_bit20_mask_in(a20_in), .cache_enable_in(ken_in), .cache_flush_in(flush_in),
		.suspend_request_in(sreq_in), .suspend_ack_in(sack_in), .sysmgmt_interrupt_in(smi_in),
		.sysmgmt_strobe_in(sstb_in), .uncacheable_out(unc_w), .write_protect_out(),
		.sysmgmt_space_out(), .force_external_out(), .use_main_mem_out(),
		.addr_bit20_mask_out(), .cache_enable_out(), .cache_flush_out(),
		.direct_mapped_out(), .suspend_request_out(), .suspend_ack_out(),
		.suspend_ack_oe_out(), .sysmgmt_interrupt_out(), .sysmgmt_strobe_out(),
		.sysmgmt_strobe_oe_out());

	io_core_model u_io_core_model (.clk_in(clk_in), .claim_in(io_claim_out),
		.external_in(io_external_out), .rdata_in(io_rdata_out), .valid_out(io_valid_in),
		.write_out(io_write_in), .addr_out(io_addr_in), .wdata_out(io_wdata_in));

	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
		u_io_core_model.cycle(wr, a, d, claim, ext, rd);
	endtask
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		io(1'b1, INDEX_PORT, idx);
		io(1'b1, DATA_PORT, d);
	endtask
	task automatic rd_reg(input logic [7:0] idx);
		io(1'b1, INDEX_PORT, idx);
		io(1'b0, DATA_PORT, 8'h00);
	endtask
	// Address is applied one edge ahead so the combinational flags have settled
	task automatic probe(input logic [31:0] a, input logic wr);
		@(posedge clk_in);
		mem_addr_in <= a;
		mem_write_in <= wr;
		@(posedge clk_in);
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_regs();
		rd_reg(IDX_CTRL0);
		chk("ctrl0 reset", 8'h00, rd);
		wr_reg(IDX_CTRL0, 8'h5A);
		rd_reg(IDX_CTRL0);
		chk("ctrl0 claim", 8'h01, {7'h00, claim});
		chk("ctrl0", 8'h5A, rd);
		wr_reg(IDX_CTRL1, 8'hFF);
		rd_reg(IDX_CTRL1);
		chk("ctrl1", 8'hFE, rd);
		wr_reg(8'hC6, 8'h3C);
		rd_reg(8'hC6);
		chk("region1 hi", 8'h3C, rd);
		io(1'b0, DATA_PORT, 8'h00);
		chk("second data claim ext", 8'h01, {6'h00, claim, ext});
		wr_reg(8'hC2, 8'h77);
		rd_reg(8'hC2);
		chk("reserved", 8'h00, rd);
		io(1'b1, INDEX_PORT, 8'hD0);
		io(1'b0, DATA_PORT, 8'h00);
		chk("out of range claim ext", 8'h01, {6'h00, claim, ext});
	endtask
	task automatic t_pins();
		wr_reg(IDX_CTRL0, 8'h00);
		wr_reg(IDX_CTRL1, 8'h00);
		chk("pins off", 8'h01, {a20_out, ken_out, flush_out, dm_out, sreq_out, sack_oe, sstb_oe,
			sack_out});
		wr_reg(IDX_CTRL0, 8'hDC);
		wr_reg(IDX_CTRL1, 8'h02);
		chk("pins on", 8'hFF, {a20_out, ken_out, flush_out, dm_out, sreq_out, sack_oe, sstb_oe,
			sack_out});
	endtask
	task automatic t_uncache();
		wr_reg(IDX_CTRL0, 8'h01);
		probe(32'h0010_8000, 1'b0);
		chk("mb low in", 8'h01, {7'h00, unc_out});
		probe(32'h0011_0000, 1'b0);
		chk("mb low out", 8'h00, {7'h00, unc_out});
		wr_reg(IDX_CTRL0, 8'h02);
		probe(32'h000B_8000, 1'b0);
		chk("upper in", 8'h01, {7'h00, unc_out});
		probe(32'h0009_0000, 1'b0);
		chk("upper out", 8'h00, {7'h00, unc_out});
	endtask
	task automatic t_region();
		wr_reg(IDX_CTRL0, 8'h00);
		wr_reg(IDX_CTRL1, 8'h00);
		wr_reg(IDX_N_REGION1, 8'h05);
		wr_reg(8'hC6, 8'h01);
		probe(32'h0001_8000, 1'b0);
		chk("region hit", 8'h01, {7'h00, unc_out});
		probe(32'h0002_0000, 1'b0);
		chk("region miss", 8'h00, {7'h00, unc_out});
		wr_reg(IDX_CTRL1, 8'h10);
		probe(32'h0001_8000, 1'b1);
		chk("protect", 8'h02, {6'h00, wp_out, unc_out});
		wr_reg(IDX_N_REGION1, 8'h00);
		probe(32'h0001_8000, 1'b1);
		chk("disabled", 8'h00, {6'h00, wp_out, unc_out});
	endtask
	task automatic t_hold();
		flush_in <= 1'b0;
		wr_reg(IDX_CTRL0, 8'h20);
		@(posedge clk_in);
		hold_enter_in <= 1'b1;
		@(posedge clk_in);
		chk("hold flush", 8'h01, {7'h00, flush_out});
		hold_enter_in <= 1'b0;
	endtask
	task automatic t_smm();
		sstb_in <= 1'b0;
		wr_reg(IDX_CTRL1, 8'h82);
		chk("smi no size", 8'h00, {7'h00, smi_out});
		wr_reg(IDX_N_REGION4, 8'h01);
		chk("smi sized", 8'h01, {7'h00, smi_out});
		wr_reg(IDX_CTRL1, 8'h02);
		chk("smi plain region", 8'h00, {7'h00, smi_out});
		wr_reg(IDX_CTRL1, 8'h86);
		probe(32'h0000_0800, 1'b0);
		chk("smm access", 8'h07, {5'h00, sstb_out, fext_out, sms_out});
		chk("smi masked", 8'h00, {7'h00, smi_out});
		probe(32'h0010_0000, 1'b0);
		chk("outside smm", 8'h00, {5'h00, sstb_out, fext_out, sms_out});
		wr_reg(IDX_CTRL1, 8'h8E);
		probe(32'h0000_0800, 1'b0);
		chk("main mem forced", 8'h01, {6'h00, sms_out, main_out});
		wr_reg(IDX_CTRL1, 8'h8A);
		in_sysmgmt_in <= 1'b1;
		probe(32'h0000_0800, 1'b0);
		chk("main mem in service", 8'h01, {6'h00, sms_out, main_out});
		in_sysmgmt_in <= 1'b0;
		probe(32'h0000_0800, 1'b0);
		chk("sm mem outside service", 8'h02, {6'h00, sms_out, main_out});
	endtask
	// Both copies see every write; the wide copy's outputs are judged here, plus the narrow copy's read of C4
	task automatic t_wide();
		wr_reg(IDX_W_REGION1, 8'h05);
		wr_reg(8'hC5, 8'h01);
		wr_reg(8'hC6, 8'h00);
		rd_reg(IDX_W_REGION1);
		chk("wide lane0", 8'h05, rdata_w);
		chk("narrow reserved C4", 8'h00, rd);
		probe(32'h0001_8000, 1'b0);
		chk("wide hit", 8'h01, {7'h00, unc_w});
		wr_reg(8'hC6, 8'h01);
		probe(32'h0101_8000, 1'b0);
		chk("wide top hit", 8'h01, {7'h00, unc_w});
		probe(32'h0001_8000, 1'b0);
		chk("wide top miss", 8'h00, {7'h00, unc_w});
	endtask

	task automatic results();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Ceiling well above the few hundred cycles the scenarios take
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			results();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_regs();
		t_pins();
		t_uncache();
		t_region();
		t_hold();
		t_smm();
		t_wide();
		results();
	end
endmodule
